// *** render_cmd_pkg.sv ***
`default_nettype none
package render_cmd_pkg;
  // ****************************************
  // Command register indices on CMD_ADDR
  // ****************************************
  localparam logic [7:0] REG_TRI_FIXED = 8'h00;
  localparam logic [7:0] REG_TRI_FLOAT = 8'h01;
  localparam logic [7:0] REG_FLUSH = 8'h02;
  localparam logic [7:0] REG_FILL = 8'h03;
  localparam logic [7:0] REG_SWAP = 8'h04;
  localparam logic [7:0] REG_COLOR_PATH = 8'h05;
  localparam logic [7:0] REG_CLIP_H = 8'h06;
  localparam logic [7:0] REG_CLIP_V = 8'h07;
  localparam logic [7:0] REG_FILL_COLOR = 8'h08;
  localparam logic [7:0] REG_DEPTH_FILL = 8'h09;
  localparam logic [7:0] REG_PIXEL_MODE = 8'h0A;
  // ****************************************
  // Field positions, widths and counts
  // ****************************************
  localparam int TRI_SIGN = 31;
  localparam int FLUSH_CLR_PIX = 0;
  localparam int FLUSH_CLR_TRI = 1;
  localparam int FILL_NO_DITHER = 0;
  localparam int SWAP_SYNC = 0;
  localparam int SWAP_DISABLE = 9;
  localparam int PM_DITHER = 8;
  localparam int PM_RGB_MASK = 9;
  localparam int PM_DEPTH_MASK = 10;
  localparam int CP_SUBPIXEL = 26;
  localparam int CP_TEXTURE = 27;
  localparam int CP_CLAMP = 28;
  localparam int CP_ANTIALIAS = 29;
  localparam int CLIP_HI_LSB = 16;
  localparam int COORD_W = 10;
  localparam int COUNT_W = 24;
  localparam int NUM_STATS = 6;
  localparam int STAT_TRI_OUT = 5;
  // ****************************************
  // Reset value and count limits
  // ****************************************
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [2:0] PENDING_MAX = 3'h7;
  localparam logic [8:0] RETRACE_MAX = 9'h1FF;
endpackage : render_cmd_pkg
`default_nettype wire

// *** render_links.sv ***
`default_nettype none
// Link between the command decoder and the rectangle fill engine
interface fill_link_if;
  logic start;
  logic [9:0] left, right, low, high;
  logic [23:0] color;
  logic [15:0] depth;
  logic dither, rgb_en, depth_en;
  logic busy, we_color, we_depth;
  logic [9:0] x, y;
  logic [15:0] pix_color, pix_depth;
  modport ctrl(output start, left, right, low, high, color, depth, dither, rgb_en,
    depth_en, input busy, we_color, we_depth, x, y, pix_color, pix_depth);
  modport engine(input start, left, right, low, high, color, depth, dither, rgb_en,
    depth_en, output busy, we_color, we_depth, x, y, pix_color, pix_depth);
endinterface : fill_link_if

// Link between the command decoder and the buffer swap engine
interface swap_link_if;
  logic push;
  logic [9:0] cmd;
  logic pend_inc, triple, vretrace_pin;
  logic [1:0] queued, disp_buf;
  logic [2:0] pending;
  logic swapped;
  modport ctrl(output push, cmd, pend_inc, triple, vretrace_pin,
    input queued, disp_buf, pending, swapped);
  modport engine(input push, cmd, pend_inc, triple, vretrace_pin,
    output queued, disp_buf, pending, swapped);
endinterface : swap_link_if
`default_nettype wire

// *** render_fill_engine.sv ***
`default_nettype none
module render_fill_engine
  import render_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  fill_link_if.engine lk
);
  typedef struct packed {
    logic busy;
    logic [9:0] x, y, left, right, high;
    logic [23:0] color;
    logic [15:0] depth;
    logic dither, rgb_en, depth_en, we_color, we_depth;
    logic [9:0] px, py;
    logic [15:0] pix_color, pix_depth;
  } fill_state_type;
  fill_state_type r, next_r;
  logic [2:0] dv;

  // Saturating add of a dither offset to one 8-bit channel
  function automatic logic [7:0] sat_add(input logic [7:0] c, input logic [2:0] a);
    logic [8:0] s;
    s = {1'b0, c} + {6'h00, a};
    sat_add = s[8] ? 8'hFF : s[7:0];
  endfunction : sat_add

  // Stepping through the rectangle, one pixel per cycle
  always_comb begin
    next_r = r;
    next_r.we_color = 1'b0;
    next_r.we_depth = 1'b0;
    dv = {r.x[0] ^ r.y[0], r.y[0], 1'b0};
    if (lk.start && !r.busy) begin
      next_r.x = lk.left;
      next_r.y = lk.low;
      next_r.left = lk.left;
      next_r.right = lk.right;
      next_r.high = lk.high;
      next_r.color = lk.color;
      next_r.depth = lk.depth;
      next_r.dither = lk.dither;
      next_r.rgb_en = lk.rgb_en;
      next_r.depth_en = lk.depth_en;
      next_r.busy = (lk.left < lk.right) && (lk.low < lk.high);
    end else if (r.busy) begin
      next_r.we_color = r.rgb_en;
      next_r.we_depth = r.depth_en;
      next_r.px = r.x;
      next_r.py = r.y;
      next_r.pix_depth = r.depth;
      if (r.dither) begin
        next_r.pix_color = {5'(sat_add(r.color[23:16], dv) >> 3),
          6'(sat_add(r.color[15:8], {1'b0, dv[2:1]}) >> 2),
          5'(sat_add(r.color[7:0], dv) >> 3)};
      end else begin
        next_r.pix_color = {r.color[23:19], r.color[15:10], r.color[7:3]};
      end
      if (r.x + 10'h001 == r.right) begin
        next_r.x = r.left;
        next_r.y = r.y + 10'h001;
        if (r.y + 10'h001 == r.high) begin
          next_r.busy = 1'b0;
        end
      end else begin
        next_r.x = r.x + 10'h001;
      end
    end
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Results back to the decoder
  assign lk.busy = r.busy;
  assign lk.we_color = r.we_color;
  assign lk.we_depth = r.we_depth;
  assign lk.x = r.px;
  assign lk.y = r.py;
  assign lk.pix_color = r.pix_color;
  assign lk.pix_depth = r.pix_depth;
endmodule : render_fill_engine
`default_nettype wire

// *** render_swap_engine.sv ***
`default_nettype none
module render_swap_engine
  import render_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  swap_link_if.engine lk
);
  typedef struct packed {
    logic s1, s2, s3, level;
    logic [8:0] rcount;
    logic [1:0][9:0] q;
    logic [1:0] queued, disp;
    logic [2:0] pending;
    logic swapped;
  } swap_state_type;
  swap_state_type r, next_r;
  logic edge_seen, done, inc, dec;

  // Retrace filter, queue, counts, display pointer
  always_comb begin
    next_r = r;
    next_r.s1 = lk.vretrace_pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    edge_seen = (r.s2 == r.s3) && (r.s3 != r.level) && r.s3;
    if (r.s2 == r.s3) begin
      next_r.level = r.s3;
    end
    // Sync flag clear ignores the interval field
    done = (r.queued != 2'h0) &&
      (!r.q[0][SWAP_SYNC] || (r.rcount > {1'b0, r.q[0][8:1]}));
    next_r.swapped = done;
    if (done) begin
      next_r.rcount = 9'h000;
    end else if (edge_seen && r.rcount != RETRACE_MAX) begin
      next_r.rcount = r.rcount + 9'h001;
    end
    if (done) begin
      next_r.q[0] = r.q[1];
    end
    if (lk.push) begin
      if (done) begin
        next_r.q[r.queued - 2'h1] = lk.cmd;
      end else begin
        next_r.q[r.queued[0]] = lk.cmd;
      end
    end
    next_r.queued = r.queued + {1'b0, lk.push} - {1'b0, done};
    if (done && !r.q[0][SWAP_DISABLE]) begin
      if (lk.triple) begin
        next_r.disp = (r.disp == 2'h2) ? 2'h0 : r.disp + 2'h1;
      end else begin
        next_r.disp = {1'b0, ~r.disp[0]};
      end
    end
    inc = lk.pend_inc && (r.pending != PENDING_MAX);
    dec = done && (r.pending != 3'h0);
    next_r.pending = r.pending + {2'h0, inc} - {2'h0, dec};
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign lk.queued = r.queued;
  assign lk.disp_buf = r.disp;
  assign lk.pending = r.pending;
  assign lk.swapped = r.swapped;
endmodule : render_swap_engine
`default_nettype wire

// *** render_cmd_path.sv ***
`default_nettype none
module render_cmd_path
  import render_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [31:0] CMD_DATA,
  output logic CMD_READY,
  input wire logic SWAP_PEND_INC,
  input wire logic TRIPLE_BUFFER_EN,
  input wire logic SGRAM_MODE,
  input wire logic PIPE_IDLE,
  input wire logic VRETRACE,
  input wire logic [5:0] STAT_EVENT,
  output logic TRI_START,
  output logic TRI_CLOCKWISE,
  output logic FLUSH_BUSY,
  output logic FILL_BUSY,
  output logic FILL_WE_COLOR,
  output logic FILL_WE_DEPTH,
  output logic [9:0] FILL_X,
  output logic [9:0] FILL_Y,
  output logic [15:0] FILL_COLOR,
  output logic [15:0] FILL_DEPTH,
  output logic SWAP_DONE,
  output logic [1:0] DISPLAY_BUFFER,
  output logic [2:0] SWAPS_PENDING,
  output logic [31:0] COLOR_PATH,
  output logic [1:0] COLOR_SRC,
  output logic [1:0] ALPHA_SRC,
  output logic [2:0] COLOR_FACTOR,
  output logic [2:0] ALPHA_FACTOR,
  output logic SUBPIXEL_EN,
  output logic TEXTURE_EN,
  output logic CLAMP_EN,
  output logic ANTIALIAS_EN,
  output logic [5:0][23:0] STAT_COUNT
);
  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [0:0] {ST_IDLE, ST_FLUSH} cmd_state_type;

  typedef struct packed {
    cmd_state_type state;
    logic ready;
    logic tri_start;
    logic tri_cw;
    logic [31:0] clip_h;
    logic [31:0] clip_v;
    logic [23:0] fill_color;
    logic [15:0] depth_fill;
    logic [31:0] pixel_mode;
    logic [31:0] color_path;
    logic [5:0][23:0] count;
  } cmd_regs_type;

  cmd_regs_type r, next_r;
  logic take;
  logic limit_ok;
  logic fill_req;
  logic swap_req;
  logic [5:0] clear_mask;

  fill_link_if fill_lk ();
  swap_link_if swap_lk ();

  // ****************************************
  // Engines
  // ****************************************
  render_fill_engine u_fill (
    .CLK(CLK),
    .NRST(NRST),
    .lk(fill_lk.engine)
  );

  render_swap_engine u_swap (
    .CLK(CLK),
    .NRST(NRST),
    .lk(swap_lk.engine)
  );

  // ****************************************
  // Command decode
  // ****************************************

  // Acceptance and per-command strobes
  assign take = CMD_VALID && r.ready;
  assign fill_req = take && (CMD_ADDR == REG_FILL);
  assign swap_req = take && (CMD_ADDR == REG_SWAP);

  // Render may run ahead by one swap only with triple buffering
  assign limit_ok = TRIPLE_BUFFER_EN ? (swap_lk.queued <= 2'h1)
    : (swap_lk.queued == 2'h0);

  // Fill parameters from stored registers, dither also gated by the fill word in SGRAM mode
  assign fill_lk.start = fill_req;
  assign fill_lk.left = r.clip_h[CLIP_HI_LSB +: COORD_W];
  assign fill_lk.right = r.clip_h[COORD_W-1:0];
  assign fill_lk.low = r.clip_v[CLIP_HI_LSB +: COORD_W];
  assign fill_lk.high = r.clip_v[COORD_W-1:0];
  assign fill_lk.color = r.fill_color;
  assign fill_lk.depth = r.depth_fill;
  assign fill_lk.dither = r.pixel_mode[PM_DITHER] &&
    !(SGRAM_MODE && CMD_DATA[FILL_NO_DITHER]);
  assign fill_lk.rgb_en = r.pixel_mode[PM_RGB_MASK];
  assign fill_lk.depth_en = r.pixel_mode[PM_DEPTH_MASK];

  // Swap engine feed
  assign swap_lk.push = swap_req;
  assign swap_lk.cmd = CMD_DATA[9:0];
  assign swap_lk.pend_inc = SWAP_PEND_INC;
  assign swap_lk.triple = TRIPLE_BUFFER_EN;
  assign swap_lk.vretrace_pin = VRETRACE;

  // Counter clear selection from a taken flush
  always_comb begin
    clear_mask = 6'h00;
    if (take && CMD_ADDR == REG_FLUSH) begin
      clear_mask[4:0] = {5{CMD_DATA[FLUSH_CLR_PIX]}};
      clear_mask[STAT_TRI_OUT] = CMD_DATA[FLUSH_CLR_TRI];
    end
  end

  // Next state of the decoder
  always_comb begin
    next_r = r;
    next_r.tri_start = 1'b0;
    if (take) begin
      case (CMD_ADDR)
        REG_TRI_FIXED, REG_TRI_FLOAT: begin
          next_r.tri_start = 1'b1;
          next_r.tri_cw = CMD_DATA[TRI_SIGN];
        end
        REG_FLUSH: begin
          next_r.state = ST_FLUSH;
        end
        REG_COLOR_PATH: begin
          next_r.color_path = CMD_DATA;
        end
        REG_CLIP_H: begin
          next_r.clip_h = CMD_DATA;
        end
        REG_CLIP_V: begin
          next_r.clip_v = CMD_DATA;
        end
        REG_FILL_COLOR: begin
          next_r.fill_color = CMD_DATA[23:0];
        end
        REG_DEPTH_FILL: begin
          next_r.depth_fill = CMD_DATA[15:0];
        end
        REG_PIXEL_MODE: begin
          next_r.pixel_mode = CMD_DATA;
        end
        default: begin
          next_r.state = r.state;
        end
      endcase
    end
    // Flush ends once the pipeline and the fill engine are empty
    case (r.state)
      ST_FLUSH: begin
        if (PIPE_IDLE && !fill_lk.busy) begin
          next_r.state = ST_IDLE;
        end
      end
      default: begin
        next_r.state = next_r.state;
      end
    endcase
    // An event in the clearing cycle is still counted
    for (int i = 0; i < NUM_STATS; i++) begin
      if (clear_mask[i]) begin
        next_r.count[i] = {23'h0, STAT_EVENT[i]};
      end else if (STAT_EVENT[i]) begin
        next_r.count[i] = r.count[i] + 24'h000001;
      end
    end
    // One idle cycle after each take lets the engines report busy
    next_r.ready = !take && (next_r.state == ST_IDLE) && !fill_lk.busy
      && limit_ok;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Decoder flops
  assign CMD_READY = r.ready;
  assign TRI_START = r.tri_start;
  assign TRI_CLOCKWISE = r.tri_cw;
  assign FLUSH_BUSY = (r.state == ST_FLUSH);
  assign STAT_COUNT = r.count;

  // Color path fields
  assign COLOR_PATH = r.color_path;
  assign COLOR_SRC = r.color_path[1:0];
  assign ALPHA_SRC = r.color_path[3:2];
  assign COLOR_FACTOR = r.color_path[12:10];
  assign ALPHA_FACTOR = r.color_path[21:19];
  assign SUBPIXEL_EN = r.color_path[CP_SUBPIXEL];
  assign TEXTURE_EN = r.color_path[CP_TEXTURE];
  assign CLAMP_EN = r.color_path[CP_CLAMP];
  assign ANTIALIAS_EN = r.color_path[CP_ANTIALIAS];

  // Fill engine flops
  assign FILL_BUSY = fill_lk.busy;
  assign FILL_WE_COLOR = fill_lk.we_color;
  assign FILL_WE_DEPTH = fill_lk.we_depth;
  assign FILL_X = fill_lk.x;
  assign FILL_Y = fill_lk.y;
  assign FILL_COLOR = fill_lk.pix_color;
  assign FILL_DEPTH = fill_lk.pix_depth;

  // Swap engine flops
  assign SWAP_DONE = swap_lk.swapped;
  assign DISPLAY_BUFFER = swap_lk.disp_buf;
  assign SWAPS_PENDING = swap_lk.pending;
endmodule : render_cmd_path
`default_nettype wire

// *** render_cmd_path_assertions.sv ***
`default_nettype none
// ****************************************
// Port checker for the command decoder
// ****************************************
module render_cmd_checker
  import render_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [31:0] CMD_DATA,
  input wire logic SWAP_PEND_INC,
  input wire logic PIPE_IDLE,
  input wire logic [5:0] STAT_EVENT,
  input wire logic TRI_START,
  input wire logic TRI_CLOCKWISE,
  input wire logic FLUSH_BUSY,
  input wire logic FILL_WE_COLOR,
  input wire logic FILL_WE_DEPTH,
  input wire logic [9:0] FILL_X,
  input wire logic [9:0] FILL_Y,
  input wire logic SWAP_DONE,
  input wire logic [2:0] SWAPS_PENDING,
  input wire logic [31:0] COLOR_PATH,
  input wire logic [1:0] COLOR_SRC,
  input wire logic [1:0] ALPHA_SRC,
  input wire logic [2:0] COLOR_FACTOR,
  input wire logic [2:0] ALPHA_FACTOR,
  input wire logic SUBPIXEL_EN,
  input wire logic TEXTURE_EN,
  input wire logic CLAMP_EN,
  input wire logic ANTIALIAS_EN,
  input wire logic [5:0][23:0] STAT_COUNT
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [9:0] lft, rgt, low, high;} clip_type;
  clip_type c, next_c;
  logic take;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  assign take = CMD_VALID && CMD_READY;
  // Shadow of the clip window as last written
  always_comb begin
    next_c = c;
    if (take && CMD_ADDR == REG_CLIP_H)
      next_c[39:20] = {CMD_DATA[25:16], CMD_DATA[9:0]};
    if (take && CMD_ADDR == REG_CLIP_V)
      next_c[19:0] = {CMD_DATA[25:16], CMD_DATA[9:0]};
  end
  // Register the shadow
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      c <= 40'h0;
    else
      c <= next_c;
  end
  sequence tri_s;
    take && (CMD_ADDR == REG_TRI_FIXED || CMD_ADDR == REG_TRI_FLOAT);
  endsequence
  sequence flush_s;
    take && CMD_ADDR == REG_FLUSH;
  endsequence
  sequence swap_now_s;
    take && CMD_ADDR == REG_SWAP && !CMD_DATA[SWAP_SYNC];
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  tri_start_a: assert property (tri_s |=>
    TRI_START && TRI_CLOCKWISE == $past(CMD_DATA[31]))
    else $error("triangle start or winding wrong");
  one_take_a: assert property (take |=> !CMD_READY)
    else $error("ready held after a take");
  flush_busy_a: assert property (flush_s |=> FLUSH_BUSY)
    else $error("flush not busy");
  flush_wait_a: assert property (FLUSH_BUSY && !PIPE_IDLE |=> FLUSH_BUSY && !CMD_READY)
    else $error("flush ended before drain");
  clear_pix_a: assert property (flush_s ##0 CMD_DATA[0] |=>
    STAT_COUNT[0] == 24'($past(STAT_EVENT[0])) && STAT_COUNT[4] == 24'($past(STAT_EVENT[4])))
    else $error("pixel counters not cleared");
  clear_tri_a: assert property (flush_s ##0 CMD_DATA[1] |=>
    STAT_COUNT[5] == 24'($past(STAT_EVENT[5])))
    else $error("triangle counter not cleared");
  keep_counts_a: assert property (flush_s ##0 CMD_DATA[1:0] == 2'h0 |=>
    STAT_COUNT[5] == $past(STAT_COUNT[5]) + 24'($past(STAT_EVENT[5])))
    else $error("counter changed by plain flush");
  fill_inside_a: assert property (FILL_WE_COLOR || FILL_WE_DEPTH |->
    FILL_X >= c.lft && FILL_X < c.rgt && FILL_Y >= c.low && FILL_Y < c.high)
    else $error("fill pixel outside clip window");
  swap_now_a: assert property (swap_now_s |-> ##2 SWAP_DONE)
    else $error("unsynced swap late");
  pend_up_a: assert property ($past(SWAP_PEND_INC) && !SWAP_DONE &&
    $past(SWAPS_PENDING) != PENDING_MAX |-> SWAPS_PENDING == $past(SWAPS_PENDING) + 3'h1)
    else $error("pending count not raised");
  pend_down_a: assert property (SWAP_DONE && !$past(SWAP_PEND_INC) &&
    $past(SWAPS_PENDING) != 3'h0 |-> SWAPS_PENDING == $past(SWAPS_PENDING) - 3'h1)
    else $error("pending count not lowered");
  path_load_a: assert property (take && CMD_ADDR == REG_COLOR_PATH |=>
    COLOR_PATH == $past(CMD_DATA))
    else $error("color path word not loaded");
  path_fields_a: assert property (
    {ANTIALIAS_EN, CLAMP_EN, TEXTURE_EN, SUBPIXEL_EN} == COLOR_PATH[29:26] &&
    ALPHA_FACTOR == COLOR_PATH[21:19] && COLOR_FACTOR == COLOR_PATH[12:10] &&
    {ALPHA_SRC, COLOR_SRC} == COLOR_PATH[3:0])
    else $error("color path fields wrong");
endmodule : render_cmd_checker

bind render_cmd_path render_cmd_checker chk (.CLK, .NRST, .CMD_VALID, .CMD_READY, .CMD_ADDR,
  .CMD_DATA, .SWAP_PEND_INC, .PIPE_IDLE, .STAT_EVENT, .TRI_START, .TRI_CLOCKWISE, .FLUSH_BUSY,
  .FILL_WE_COLOR, .FILL_WE_DEPTH, .FILL_X, .FILL_Y, .SWAP_DONE, .SWAPS_PENDING, .COLOR_PATH,
  .COLOR_SRC, .ALPHA_SRC, .COLOR_FACTOR, .ALPHA_FACTOR, .SUBPIXEL_EN, .TEXTURE_EN, .CLAMP_EN,
  .ANTIALIAS_EN, .STAT_COUNT);
`default_nettype wire

// *** render_host_model.sv ***
`default_nettype none
// ****************************************
// Host FIFO output, in order
// ****************************************
module render_host_model (
  input wire logic CLK,
  input wire logic CMD_READY,
  output logic CMD_VALID,
  output logic [7:0] CMD_ADDR,
  output logic [31:0] CMD_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] q[$];
  // Queue a word behind those already waiting
  task automatic push(input logic [7:0] a, input logic [31:0] d);
    q.push_back({a, d});
  endtask : push
  initial begin
    CMD_VALID = 1'b0;
    CMD_ADDR = 8'h00;
    CMD_DATA = 32'h0000_0000;
  end
  // Retire on accept, offer next word or scramble bus
  always @(posedge CLK) begin
    if (CMD_VALID && CMD_READY)
      void'(q.pop_front());
    #1;
    CMD_VALID = (q.size() != 0);
    if (CMD_VALID)
      {CMD_ADDR, CMD_DATA} = q[0];
    else
      {CMD_ADDR, CMD_DATA} = ~{CMD_ADDR, CMD_DATA};
  end
endmodule : render_host_model
`default_nettype wire

// *** render_command_and_color_path_bench.sv ***
`default_nettype none
module render_command_and_color_path_bench
  import render_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, NRST, CMD_READY, SWAP_PEND_INC, TRIPLE_BUFFER_EN, SGRAM_MODE, PIPE_IDLE;
  logic VRETRACE, CMD_VALID, TRI_START, TRI_CLOCKWISE, FLUSH_BUSY, FILL_BUSY, SWAP_DONE;
  logic FILL_WE_COLOR, FILL_WE_DEPTH, SUBPIXEL_EN, TEXTURE_EN, CLAMP_EN, ANTIALIAS_EN, rt_on;
  logic [7:0] CMD_ADDR;
  logic [31:0] CMD_DATA, COLOR_PATH, d;
  logic [9:0] FILL_X, FILL_Y, w, h, lft, low;
  logic [15:0] FILL_COLOR, FILL_DEPTH, seen_col, seen_dep, fd;
  logic [1:0] DISPLAY_BUFFER, COLOR_SRC, ALPHA_SRC, eb, m;
  logic [2:0] SWAPS_PENDING, COLOR_FACTOR, ALPHA_FACTOR;
  logic [5:0] STAT_EVENT;
  logic [5:0][23:0] STAT_COUNT, model;
  logic [23:0] fc;
  int miscompares, checks_done, n_col, n_dep, n_tri, rt_t, rt_cnt, rt_done;
  render_cmd_path DUT (.CLK, .NRST, .CMD_VALID, .CMD_ADDR, .CMD_DATA, .CMD_READY,
    .SWAP_PEND_INC, .TRIPLE_BUFFER_EN, .SGRAM_MODE, .PIPE_IDLE, .VRETRACE, .STAT_EVENT,
    .TRI_START, .TRI_CLOCKWISE, .FLUSH_BUSY, .FILL_BUSY, .FILL_WE_COLOR, .FILL_WE_DEPTH,
    .FILL_X, .FILL_Y, .FILL_COLOR, .FILL_DEPTH, .SWAP_DONE, .DISPLAY_BUFFER, .SWAPS_PENDING,
    .COLOR_PATH, .COLOR_SRC, .ALPHA_SRC, .COLOR_FACTOR, .ALPHA_FACTOR, .SUBPIXEL_EN,
    .TEXTURE_EN, .CLAMP_EN, .ANTIALIAS_EN, .STAT_COUNT);
  render_host_model HOST (.CLK, .CMD_READY, .CMD_VALID, .CMD_ADDR, .CMD_DATA);
  // ****************************************
  // Clock, retrace pulses and monitors
  // ****************************************
  always #5 CLK = ~CLK;
  // Four-cycle retrace every sixty cycles while enabled
  always @(posedge CLK) begin
    #1;
    rt_t = rt_on ? rt_t + 1 : 0;
    VRETRACE = rt_on && (rt_t % 60 > 55);
    if (rt_on && rt_t % 60 == 56)
      rt_cnt++;
  end
  // Count events, pixel writes and triangle starts, note the retrace count at each swap
  always @(posedge CLK) begin
    for (int i = 0; i < 6; i++)
      if (STAT_EVENT[i])
        model[i] = model[i] + 24'h1;
    if (FILL_WE_COLOR === 1'b1) begin
      n_col++;
      if (n_col == 1)
        seen_col = FILL_COLOR;
    end
    if (FILL_WE_DEPTH === 1'b1) begin
      n_dep++;
      seen_dep = FILL_DEPTH;
    end
    if (TRI_START === 1'b1)
      n_tri++;
    if (SWAP_DONE === 1'b1)
      rt_done = rt_cnt;
  end
  // ****************************************
  // Tasks and expectations
  // ****************************************
  function automatic logic [15:0] to565(input logic [23:0] c, input logic [2:0] o);
    c = c + {5'h0, o, 6'h0, o[2:1], 5'h0, o};
    return {c[23:19], c[15:10], c[7:3]};
  endfunction : to565
  function automatic logic [31:0] fields(input logic [31:0] p);
    return {18'h0, p[29:26], p[21:19], p[12:10], p[3:0]};
  endfunction : fields
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Wait for empty queue, ready decoder, no pending swap
  task automatic settle;
    int n;
    n = 0;
    while ((HOST.q.size() != 0 || CMD_READY !== 1'b1 || SWAPS_PENDING !== 0) && n < 3000) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n == 3000) begin
      miscompares++;
      wrap_up();
    end
  endtask : settle
  task automatic cmd(input logic [7:0] a, input logic [31:0] v);
    HOST.push(a, v);
    settle();
  endtask : cmd
  task automatic pend_inc;
    SWAP_PEND_INC = 1'b1;
    @(posedge CLK);
    #1;
    SWAP_PEND_INC = 1'b0;
  endtask : pend_inc
  task automatic swap(input logic [31:0] v);
    logic [2:0] p;
    p = SWAPS_PENDING;
    pend_inc();
    chk("pending up", 32'(p + 3'h1), 32'(SWAPS_PENDING));
    cmd(REG_SWAP, v);
  endtask : swap
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    CLK = 1'b0;
    NRST = 1'b0;
    SWAP_PEND_INC = 1'b0;
    TRIPLE_BUFFER_EN = 1'b0;
    SGRAM_MODE = 1'b0;
    PIPE_IDLE = 1'b1;
    VRETRACE = 1'b0;
    STAT_EVENT = 6'h00;
    rt_on = 1'b0;
    model = 144'h0;
    eb = 2'h0;
    void'($urandom(68));
    repeat (5) @(posedge CLK);
    #1 NRST = 1'b1;
    @(posedge CLK);
    #1 chk("reset state", 32'h0, 32'({COLOR_PATH[0], SWAPS_PENDING, DISPLAY_BUFFER, FLUSH_BUSY,
      FILL_BUSY}));
    // Triangles on both command words, then an unknown index
    n_tri = 0;
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'h7FFF_FFFF : $urandom;
      cmd((i % 2) ? REG_TRI_FLOAT : REG_TRI_FIXED, d);
      chk("triangle winding", 32'(d[31]), 32'(TRI_CLOCKWISE));
    end
    cmd(8'hF0, 32'hFFFF_FFFF);
    chk("triangle starts", 32'h8, n_tri);
    // Color path words
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      cmd(REG_COLOR_PATH, d);
      chk("path word", d, COLOR_PATH);
      chk("path fields", fields(d), 32'({ANTIALIAS_EN, CLAMP_EN, TEXTURE_EN, SUBPIXEL_EN,
        ALPHA_FACTOR, COLOR_FACTOR, ALPHA_SRC, COLOR_SRC}));
    end
    // Flush in each clear mode, pipeline busy
    for (int k = 0; k < 4; k++) begin
      repeat (20) begin
        STAT_EVENT = 6'($urandom);
        @(posedge CLK);
        #1;
      end
      STAT_EVENT = 6'h00;
      PIPE_IDLE = 1'b0;
      n_tri = 0;
      HOST.push(REG_FLUSH, {30'($urandom), 2'(k)});
      HOST.push(REG_TRI_FLOAT, 32'h0);
      repeat (10) @(posedge CLK);
      #1 chk("flush busy", 32'h1, 32'(FLUSH_BUSY));
      chk("held behind flush", 32'h0, n_tri);
      PIPE_IDLE = 1'b1;
      settle();
      for (int i = 0; i < 6; i++) begin
        if ((i < 5) ? k[0] : k[1])
          model[i] = 24'h0;
        chk("stat count", 32'(model[i]), 32'(STAT_COUNT[i]));
      end
    end
    // Fills: mask pairs, empty, dither, block-write
    for (int i = 0; i < 5; i++) begin
      w = (i == 3) ? 10'h0 : 10'($urandom_range(4, 1));
      h = 10'($urandom_range(3, 1));
      lft = 10'($urandom_range(500));
      low = 10'($urandom_range(500));
      fc = 24'($urandom) & 24'h7F7F7F;
      fd = 16'($urandom);
      m = (i == 4) ? 2'h1 : 2'(i);
      SGRAM_MODE = (i > 1);
      cmd(REG_CLIP_H, {6'h0, lft, 6'h0, lft + w});
      cmd(REG_CLIP_V, {6'h0, low, 6'h0, low + h});
      cmd(REG_FILL_COLOR, {8'h0, fc});
      cmd(REG_DEPTH_FILL, {16'h0, fd});
      cmd(REG_PIXEL_MODE, {21'h0, m, i % 3 == 1, 8'h0});
      n_col = 0;
      n_dep = 0;
      cmd(REG_FILL, {31'h0, i == 4});
      chk("color writes", m[0] ? 32'(w * h) : 32'h0, n_col);
      chk("depth writes", m[1] ? 32'(w * h) : 32'h0, n_dep);
      if (m[0] && w != 10'h0)
        chk("fill color", 32'(to565(fc, (i == 1) ? {lft[0] ^ low[0], low[0], 1'b0} : 3'h0)),
          32'(seen_col));
      if (m[1] && w != 10'h0)
        chk("fill depth", 32'(fd), 32'(seen_dep));
    end
    // Unsynced swaps with random interval, then a disabled swap
    for (int i = 0; i < 4; i++) begin
      swap({22'h0, i == 3, 8'($urandom), 1'b0});
      if (i < 3)
        eb = eb ^ 2'h1;
      chk("display buffer", 32'(eb), 32'(DISPLAY_BUFFER));
      chk("pending down", 32'h0, 32'(SWAPS_PENDING));
    end
    // Synced swap with interval one waits for two retraces
    rt_cnt = 0;
    rt_on = 1'b1;
    swap(32'h0000_0003);
    chk("retraces waited", 32'h2, rt_done);
    rt_on = 1'b0;
    eb = eb ^ 2'h1;
    // Render ahead only with triple buffering
    for (int t = 0; t < 2; t++) begin
      TRIPLE_BUFFER_EN = (t == 1);
      n_tri = 0;
      pend_inc();
      HOST.push(REG_SWAP, 32'h0000_0001);
      HOST.push(REG_TRI_FIXED, 32'h0);
      repeat (30) @(posedge CLK);
      #1 chk("render ahead", t, n_tri);
      rt_cnt = 0;
      rt_on = 1'b1;
      settle();
      rt_on = 1'b0;
      eb = (t == 1) ? eb + 2'h1 : eb ^ 2'h1;
      chk("display buffer", 32'(eb), 32'(DISPLAY_BUFFER));
    end
    for (int i = 0; i < 2; i++) begin
      swap(32'h0000_0000);
      eb = (eb == 2'h2) ? 2'h0 : eb + 2'h1;
      chk("triple buffer", 32'(eb), 32'(DISPLAY_BUFFER));
    end
    wrap_up();
  end
endmodule : render_command_and_color_path_bench
`default_nettype wire
